// >>> logic/sleep_wake_pkg.sv
// Shared constants and types for the sleep and wake-up controller
package sleep_wake_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] OPTION_IDX   = 16'h0081;
  localparam logic [15:0] CONFIG_IDX   = 16'h2007;
  localparam logic [15:0] STATUS_IDX   = 16'h0003;
  localparam logic [15:0] IRQ_CTRL_IDX = 16'h000b;
  localparam logic [15:0] ID_FIRST_IDX = 16'h2000;
  localparam logic [15:0] ID_LAST_IDX  = 16'h2003;
  // Reset values
  localparam logic [7:0]  OPTION_RESET = 8'hff;
  localparam logic [7:0]  CONFIG_RESET = 8'hff;
  // Field positions
  localparam int unsigned PD_BIT    = 3;
  localparam int unsigned TO_BIT    = 4;
  localparam int unsigned GIE_BIT   = 7;
  localparam int unsigned PSA_BIT   = 3;
  localparam int unsigned PS_LSB    = 0;
  localparam int unsigned WATCHDOG_ENABLE_CFG_BIT  = 2;
  localparam int unsigned FOSC_LSB  = 0;
  localparam int unsigned CP_LSB    = 4;
  localparam logic [3:0]  CP_UNPROG = 4'hf;
  localparam logic [1:0]  OSC_RC    = 2'h3;
  localparam int unsigned ID_W      = 4;
  localparam int unsigned N_SRC     = 4;
  // Sources clocked by the phase clocks (timer overflow)
  localparam logic [3:0]  PHASE_SRCS = 4'h1;
  // Program counter
  localparam int unsigned PC_W    = 13;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [12:0] VECTOR  = 13'h0004;
  // Start-up delay in oscillator periods, and periods per ref_clk
  localparam int unsigned OST_OSC_PERIODS = 1024;
  localparam int unsigned OSC_PER_CLK     = 1;
  localparam int unsigned OST_CYCLES      = OST_OSC_PERIODS / OSC_PER_CLK;
  // Watchdog base period in watchdog oscillator ticks
  localparam int unsigned WDT_BASE_TICKS  = 256;
  typedef enum logic [2:0] {RUN, ASLEEP, OSC_START, EXEC_NEXT, DUMMY_A, DUMMY_B} state_type;
endpackage

// >>> logic/sleep_watchdog.sv
// Watchdog counter with optional postscaler
`timescale 1ns/1ps
module sleep_watchdog #(
  parameter int unsigned BASE_TICKS = sleep_wake_pkg::WDT_BASE_TICKS
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       osc_tick,
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic       postscale_on,
  input  wire logic [2:0] ratio,
  output logic            expire
);
  localparam int unsigned BW = $clog2(BASE_TICKS);
  logic [BW-1:0] base_reg;
  logic [6:0]    post_reg;
  logic [6:0]    post_lim;
  logic          expire_reg;

  assign post_lim = 7'((8'h01 << ratio) - 8'h01);
  assign expire   = expire_reg;

  // Own tick keeps counting while the core clock is gated off
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || clear)
    begin
      base_reg   <= '0;
      post_reg   <= '0;
      expire_reg <= 1'b0;
    end
    else
    begin
      expire_reg <= 1'b0;
      if (enable && osc_tick)
      begin
        if (base_reg == BW'(BASE_TICKS - 1))
        begin
          base_reg <= '0;
          if (!postscale_on || post_reg == post_lim)
          begin
            post_reg   <= '0;
            expire_reg <= 1'b1;
          end
          else
            post_reg <= post_reg + 7'h01;
        end
        else
          base_reg <= base_reg + BW'(1);
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wdt_advance_a: assert property (enable && osc_tick && !clear
    && base_reg != BW'(BASE_TICKS - 1) |=> base_reg == $past(base_reg) + BW'(1))
    else $error("watchdog did not advance on its tick");
  wdt_off_a: assert property (!enable |=> !expire_reg)
    else $error("watchdog expired while disabled");
endmodule

// >>> logic/sleep_ost_timer.sv
// Oscillator start-up delay counter
`timescale 1ns/1ps
module sleep_ost_timer #(
  parameter int unsigned CYCLES = sleep_wake_pkg::OST_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      done
);
  localparam int unsigned CW = $clog2(CYCLES) + 1;
  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic          done_reg;

  assign done = done_reg;

  // Count the whole delay, then one done pulse
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start)
      begin
        busy_reg <= 1'b1;
        cnt_reg  <= '0;
      end
      else if (busy_reg)
      begin
        if (cnt_reg == CW'(CYCLES - 1))
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  ost_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done_reg |-> $past(cnt_reg) == CW'(CYCLES - 1) && $past(busy_reg))
    else $error("start-up delay ended early");
endmodule

// >>> logic/sleep_wake_control.sv
// Sleep entry, wake-up and watchdog control with APB registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module sleep_wake_control #(
  parameter int unsigned WDT_TICKS = sleep_wake_pkg::WDT_BASE_TICKS,
  parameter int unsigned OST_LEN   = sleep_wake_pkg::OST_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_instr,
  input  wire logic        watchdog_clear_instr,
  input  wire logic [12:0] pc,
  input  wire logic        external_reset_pin_n,
  input  wire logic        wdt_osc_tick,
  input  wire logic [3:0]  irq_flags,
  input  wire logic        prog_mode,
  output logic             core_run,
  output logic             osc_drive_on,
  output logic             io_hold,
  output logic             device_reset,
  output logic             reset_pin_oe,
  output logic             prefetch_req,
  output logic      [12:0] prefetch_addr,
  output logic             exec_prefetched,
  output logic             dummy_cycle,
  output logic             vector_load,
  output logic             stack_push,
  output logic      [12:0] vector_addr,
  output logic             power_down_flag,
  output logic             expiry_flag,
  output logic             global_irq_enable,
  output logic             verify_read_allow
);
  sleep_wake_pkg::state_type state_reg;
  sleep_wake_pkg::state_type state_next;
  logic [7:0]  option_reg;
  logic [7:0]  config_reg;
  logic [3:0]  irq_en_reg;
  logic        gie_reg;
  logic        pd_reg;
  logic        to_reg;
  logic        vec_pend_reg;
  logic [3:0]  id_reg [4];
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        core_run_reg;
  logic        osc_reg;
  logic        io_hold_reg;
  logic        dev_rst_reg;
  logic        pin_oe_reg;
  logic        prefetch_reg;
  logic [12:0] pf_addr_reg;
  logic        exec_reg;
  logic        dummy_reg;
  logic        vec_load_reg;
  logic        push_reg;
  logic [12:0] vec_addr_reg;
  logic        verify_reg;
  logic        wdt_expire;
  logic        ost_done;
  logic        pending;
  logic        wake_irq;
  logic        sleep_go;
  logic        sleep_nop;
  logic        wdt_fire;
  logic        external_reset_pin_rst;
  logic        wdt_rst;
  logic        any_rst;
  logic        crystal;
  logic        wake;
  logic        acc;
  logic        wr_en;
  logic [13:0] idx;
  logic        id_sel;

  // Output ports straight from flip-flops
  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign core_run          = core_run_reg;
  assign osc_drive_on      = osc_reg;
  assign io_hold           = io_hold_reg;
  assign device_reset      = dev_rst_reg;
  assign reset_pin_oe      = pin_oe_reg;
  assign prefetch_req      = prefetch_reg;
  assign prefetch_addr     = pf_addr_reg;
  assign exec_prefetched   = exec_reg;
  assign dummy_cycle       = dummy_reg;
  assign vector_load       = vec_load_reg;
  assign stack_push        = push_reg;
  assign vector_addr       = vec_addr_reg;
  assign power_down_flag   = pd_reg;
  assign expiry_flag       = to_reg;
  assign global_irq_enable = gie_reg;
  assign verify_read_allow = verify_reg;

  // Event decode
  assign pending   = |(irq_flags & irq_en_reg);
  assign wake_irq  = |(irq_flags & irq_en_reg & ~sleep_wake_pkg::PHASE_SRCS);
  assign sleep_nop = state_reg == sleep_wake_pkg::RUN && sleep_instr && pending && !gie_reg;
  assign sleep_go  = state_reg == sleep_wake_pkg::RUN && sleep_instr && !sleep_nop;
  assign wdt_fire  = wdt_expire && config_reg[sleep_wake_pkg::WATCHDOG_ENABLE_CFG_BIT];
  assign external_reset_pin_rst  = !external_reset_pin_n;
  assign wdt_rst   = wdt_fire && state_reg != sleep_wake_pkg::ASLEEP;
  assign any_rst   = external_reset_pin_rst || wdt_rst;
  assign crystal   = config_reg[sleep_wake_pkg::FOSC_LSB +: 2] != sleep_wake_pkg::OSC_RC;
  assign wake      = state_reg == sleep_wake_pkg::ASLEEP && (wdt_fire || wake_irq);

  // Watchdog clears on sleep and on its clear instruction
  sleep_watchdog #(.BASE_TICKS(WDT_TICKS)) u_wdt (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .osc_tick     (wdt_osc_tick),
    .clear        (sleep_go || watchdog_clear_instr),
    .enable       (config_reg[sleep_wake_pkg::WATCHDOG_ENABLE_CFG_BIT]),
    .postscale_on (option_reg[sleep_wake_pkg::PSA_BIT]),
    .ratio        (option_reg[sleep_wake_pkg::PS_LSB +: 3]),
    .expire       (wdt_expire)
  );

  sleep_ost_timer #(.CYCLES(OST_LEN)) u_ost (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (wake && crystal),
    .done    (ost_done)
  );

  // Power state sequencing; a pin or watchdog reset returns to running
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sleep_wake_pkg::RUN:
        if (sleep_go)
          state_next = sleep_wake_pkg::ASLEEP;
      sleep_wake_pkg::ASLEEP:
        if (wake)
          state_next = crystal ? sleep_wake_pkg::OSC_START : sleep_wake_pkg::EXEC_NEXT;
      sleep_wake_pkg::OSC_START:
        if (ost_done)
          state_next = sleep_wake_pkg::EXEC_NEXT;
      sleep_wake_pkg::EXEC_NEXT:
        state_next = (vec_pend_reg && gie_reg) ? sleep_wake_pkg::DUMMY_A
                                               : sleep_wake_pkg::RUN;
      sleep_wake_pkg::DUMMY_A:
        state_next = sleep_wake_pkg::DUMMY_B;
      sleep_wake_pkg::DUMMY_B:
        state_next = sleep_wake_pkg::RUN;
      default:
        state_next = sleep_wake_pkg::RUN;
    endcase
    if (any_rst)
      state_next = sleep_wake_pkg::RUN;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      state_reg <= sleep_wake_pkg::RUN;
    else
      state_reg <= state_next;
  end

  // Remember whether an interrupt caused the wake
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      vec_pend_reg <= 1'b0;
    else if (wake)
      vec_pend_reg <= wake_irq && !wdt_fire;
  end

  // Core-facing strobes and levels, registered from the next state; device reset from any_rst; vector load and stack push from the current DUMMY_B state
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      core_run_reg <= 1'b1;
      osc_reg      <= 1'b1;
      io_hold_reg  <= 1'b0;
      dev_rst_reg  <= 1'b1;
      exec_reg     <= 1'b0;
      dummy_reg    <= 1'b0;
      vec_load_reg <= 1'b0;
      push_reg     <= 1'b0;
    end
    else
    begin
      core_run_reg <= state_next == sleep_wake_pkg::RUN;
      osc_reg      <= state_next != sleep_wake_pkg::ASLEEP;
      io_hold_reg  <= state_next == sleep_wake_pkg::ASLEEP
                      || state_next == sleep_wake_pkg::OSC_START;
      dev_rst_reg  <= any_rst;
      exec_reg     <= state_next == sleep_wake_pkg::EXEC_NEXT;
      dummy_reg    <= state_next == sleep_wake_pkg::DUMMY_A
                      || state_next == sleep_wake_pkg::DUMMY_B;
      vec_load_reg <= state_reg == sleep_wake_pkg::DUMMY_B && !any_rst;
      push_reg     <= state_reg == sleep_wake_pkg::DUMMY_B && !any_rst;
    end
  end

  // Reset pin is input only; a watchdog reset stays inside
  always_ff @(posedge ref_clk)
  begin
    pin_oe_reg   <= 1'b0;
    vec_addr_reg <= sleep_wake_pkg::VECTOR;
  end

  // Next-address prefetch while sleep executes
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      prefetch_reg <= 1'b0;
      pf_addr_reg  <= '0;
    end
    else
    begin
      prefetch_reg <= sleep_go;
      if (sleep_go)
        pf_addr_reg <= pc + sleep_wake_pkg::PC_STEP;
    end
  end

  // Status flags; a pin reset leaves them as they were
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pd_reg <= 1'b1;
      to_reg <= 1'b1;
    end
    else if (wdt_fire)
      to_reg <= 1'b0;
    else if (sleep_go)
    begin
      pd_reg <= 1'b0;
      to_reg <= 1'b1;
    end
    else if (watchdog_clear_instr && state_reg == sleep_wake_pkg::RUN)
    begin
      pd_reg <= 1'b1;
      to_reg <= 1'b1;
    end
  end

  // APB: one wait state so read data comes from a flip-flop
  assign acc    = psel && penable;
  assign wr_en  = acc && pready_reg && pwrite;
  assign idx    = paddr[15:2];
  assign id_sel = idx >= sleep_wake_pkg::ID_FIRST_IDX[13:0]
                  && idx <= sleep_wake_pkg::ID_LAST_IDX[13:0];

  always_comb
  begin
    rd_val = '0;
    rd_hit = paddr[1:0] == 2'h0;
    case (idx)
      sleep_wake_pkg::OPTION_IDX[13:0]:
        rd_val[7:0] = option_reg;
      sleep_wake_pkg::CONFIG_IDX[13:0]:
        rd_val[7:0] = config_reg;
      sleep_wake_pkg::STATUS_IDX[13:0]:
      begin
        rd_val[sleep_wake_pkg::PD_BIT] = pd_reg;
        rd_val[sleep_wake_pkg::TO_BIT] = to_reg;
      end
      sleep_wake_pkg::IRQ_CTRL_IDX[13:0]:
      begin
        rd_val[sleep_wake_pkg::GIE_BIT] = gie_reg;
        rd_val[sleep_wake_pkg::N_SRC-1:0] = irq_en_reg;
      end
      default:
        if (id_sel && prog_mode)
          rd_val[sleep_wake_pkg::ID_W-1:0] = id_reg[idx[1:0]];
        else
          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else
    begin
      pready_reg <= acc && !pready_reg;
      if (acc && !pready_reg)
      begin
        pslverr_reg <= !rd_hit;
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Option register, set to all ones by every kind of reset
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || any_rst)
      option_reg <= sleep_wake_pkg::OPTION_RESET;
    else if (wr_en && idx == sleep_wake_pkg::OPTION_IDX[13:0])
      option_reg <= pwdata[7:0];
  end

  // Configuration and identification words change only in program mode
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      config_reg <= sleep_wake_pkg::CONFIG_RESET;
      for (int i = 0; i < 4; i++)
        id_reg[i] <= '0;
    end
    else if (wr_en && prog_mode)
    begin
      if (idx == sleep_wake_pkg::CONFIG_IDX[13:0])
        config_reg <= pwdata[7:0];
      if (id_sel && paddr[1:0] == 2'h0)
        id_reg[idx[1:0]] <= pwdata[sleep_wake_pkg::ID_W-1:0];
    end
  end

  // Verify readout allowed only while protection is erased
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      verify_reg <= 1'b0;
    else
      verify_reg <= config_reg[sleep_wake_pkg::CP_LSB +: 4] == sleep_wake_pkg::CP_UNPROG;
  end

  // Interrupt control; vectoring clearance wins over a software write
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || any_rst)
    begin
      gie_reg    <= 1'b0;
      irq_en_reg <= '0;
    end
    else
    begin
      if (wr_en && idx == sleep_wake_pkg::IRQ_CTRL_IDX[13:0])
      begin
        irq_en_reg <= pwdata[sleep_wake_pkg::N_SRC-1:0];
        gie_reg    <= pwdata[sleep_wake_pkg::GIE_BIT];
      end
      if (state_reg == sleep_wake_pkg::DUMMY_B)
        gie_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sleep_cause_a: assert property (state_reg == sleep_wake_pkg::RUN && !sleep_instr
    |=> state_reg != sleep_wake_pkg::ASLEEP)
    else $error("sleep entered without the instruction");
  sleep_entry_a: assert property (sleep_go && !wdt_fire && !any_rst
    |=> !power_down_flag && expiry_flag && !osc_drive_on)
    else $error("sleep entry flags or oscillator wrong");
  pin_hold_a: assert property (state_reg == sleep_wake_pkg::ASLEEP |-> io_hold)
    else $error("pins released during sleep");
  pin_quiet_a: assert property (!reset_pin_oe)
    else $error("reset pin driven");
  phase_irq_a: assert property (state_reg == sleep_wake_pkg::ASLEEP && !wake_irq
    && !wdt_fire && !external_reset_pin_rst |=> state_reg == sleep_wake_pkg::ASLEEP)
    else $error("woke without an enabled source");
  external_reset_pin_wake_a: assert property (state_reg == sleep_wake_pkg::ASLEEP && external_reset_pin_rst
    |=> device_reset && state_reg == sleep_wake_pkg::RUN)
    else $error("reset pin wake did not reset");
  wdt_wake_a: assert property (state_reg == sleep_wake_pkg::ASLEEP && wdt_fire
    && !external_reset_pin_rst |=> !expiry_flag && !device_reset)
    else $error("watchdog wake flag or reset wrong");
  prefetch_a: assert property (sleep_go
    |=> prefetch_req && prefetch_addr == $past(pc) + sleep_wake_pkg::PC_STEP)
    else $error("prefetch address wrong");
  irq_wake_a: assert property (state_reg == sleep_wake_pkg::ASLEEP && wake_irq
    && !any_rst |=> state_reg inside {sleep_wake_pkg::OSC_START, sleep_wake_pkg::EXEC_NEXT})
    else $error("enabled interrupt did not wake");
  sleep_nop_a: assert property (sleep_nop && !any_rst && !watchdog_clear_instr
    |=> state_reg == sleep_wake_pkg::RUN && $stable(power_down_flag))
    else $error("sleep not treated as no-op");
  vector_seq_a: assert property (state_reg == sleep_wake_pkg::EXEC_NEXT && vec_pend_reg
    && gie_reg && !any_rst ##1 !any_rst ##1 !any_rst
    |=> vector_load && stack_push && !global_irq_enable && $past(dummy_cycle, 2))
    else $error("vector sequence wrong");
  option_reset_a: assert property (device_reset
    |-> option_reg == sleep_wake_pkg::OPTION_RESET)
    else $error("option register not reset");

  cover_sleep_c: cover property (sleep_go ##1 state_reg == sleep_wake_pkg::ASLEEP);
  cover_wdt_c: cover property (state_reg == sleep_wake_pkg::ASLEEP && wdt_fire);
  cover_vec_c: cover property (vector_load);
  cover_nop_c: cover property (sleep_nop);
endmodule

// >>> verification/irq_source_model.sv
// Far-side model: reset pin, interrupt flag sources, watchdog oscillator
`timescale 1ns/1ps
module irq_source_model #(
  parameter int unsigned TICK_DIV = 8
) (
  input  wire logic       ref_clk,
  input  wire logic [3:0] flag_set,
  input  wire logic       flag_clear,
  input  wire logic       pin_low,
  output logic      [3:0] irq_flags,
  output logic            external_reset_pin_n,
  output logic            wdt_osc_tick
);
  logic [3:0] flags_reg = 4'h0;
  logic [7:0] div_reg   = 8'h00;
  // Flags latch until cleared, as real sources do
  always @(posedge ref_clk)
  begin
    flags_reg <= flag_clear ? 4'h0 : (flags_reg | flag_set);
    div_reg   <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
  end
  assign irq_flags            = flags_reg;
  // Pulled up, so a released pin reads high
  assign external_reset_pin_n = ~pin_low;
  // Free-running, also while the core sleeps
  assign wdt_osc_tick         = (div_reg == 8'h00);
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned OST = 8;
  logic        ref_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        sleep_instr = 1'h0, watchdog_clear_instr = 1'h0, prog_mode = 1'h0;
  logic        flag_clear = 1'h0, pin_low = 1'h0, pready, pslverr, external_reset_pin_n;
  logic        wdt_osc_tick, core_run, osc_drive_on, io_hold, device_reset, reset_pin_oe;
  logic        prefetch_req, exec_prefetched, dummy_cycle, vector_load, stack_push;
  logic        power_down_flag, expiry_flag, global_irq_enable, verify_read_allow;
  logic [3:0]  irq_flags, flag_set = 4'h0;
  logic [12:0] pc = 13'h0000, prefetch_addr, vector_addr;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [33:0] e, exp_q[$];
  int          miscompares = 0, tests_run = 0, n, seed = 32'h6a2413b5;
  always #25 ref_clk = ~ref_clk;
  sleep_wake_control #(.WDT_TICKS(4), .OST_LEN(OST)) dut (.ref_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
    .watchdog_clear_instr, .pc, .external_reset_pin_n, .wdt_osc_tick, .irq_flags, .prog_mode,
    .core_run, .osc_drive_on, .io_hold, .device_reset, .reset_pin_oe, .prefetch_req,
    .prefetch_addr, .exec_prefetched, .dummy_cycle, .vector_load, .stack_push, .vector_addr,
    .power_down_flag, .expiry_flag, .global_irq_enable, .verify_read_allow);
  irq_source_model far (.ref_clk, .flag_set, .flag_clear, .pin_low, .irq_flags,
    .external_reset_pin_n, .wdt_osc_tick);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Note the expected answer, then hold the request until pready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] v,
                     input logic err);
    exp_q.push_back({wr, err, v});
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1)
      @(posedge ref_clk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Bounded wait; settled values are read just after each edge
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n < lim, 1);
  endtask
  task automatic do_sleep(input logic [12:0] p, input logic noop);
    sleep_instr <= 1'h1;
    pc <= p;
    @(posedge ref_clk);
    sleep_instr <= 1'h0;
    #1;
    check({core_run, osc_drive_on, io_hold, power_down_flag, expiry_flag},
          {noop, noop, !noop, noop, 1'h1});
    if (!noop)
      check({prefetch_req, prefetch_addr}, {1'h1, p + 13'h1});
    @(posedge ref_clk);
  endtask
  task automatic clear_flags;
    flag_clear <= 1'h1;
    flag_set <= 4'h0;
    @(posedge ref_clk);
    flag_clear <= 1'h0;
  endtask
  // Oldest note against each completed transfer
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'h1)
    begin
      e = exp_q.pop_front();
      check(pslverr, e[32]);
      if (!e[33])
        check(prdata, e[31:0]);
    end
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    apb(1'h0, 16'h0204, 32'hff, 1'h0);
    apb(1'h0, 16'h000c, 32'h18, 1'h0);
    apb(1'h0, 16'h0100, 32'h0, 1'h1);
    apb(1'h0, 16'h8000, 32'h0, 1'h1);
    prog_mode <= 1'h1;
    d = $random(seed);
    apb(1'h1, 16'h8004, d, 1'h0);
    apb(1'h0, 16'h8004, {28'h0, d[3:0]}, 1'h0);
    apb(1'h1, 16'h801c, 32'hf3, 1'h0);
    // Each wake source, vectored when the global enable is set
    for (int s = 1; s < 4; s++)
    begin
      apb(1'h1, 16'h002c, (s[0] ? 32'h81 : 32'h01) | (32'h1 << s), 1'h0);
      do_sleep(13'($random(seed)), 1'h0);
      flag_set <= 4'h1;
      repeat (3) @(posedge ref_clk);
      flag_set <= 4'(1 << s);
      #1;
      check({io_hold, verify_read_allow}, 2'h3);
      // Slot after sleep is taken to hold a no-op, so in-line resume is harmless
      wait_for(exec_prefetched, 1'h1, 4);
      repeat (2)
      begin
        @(posedge ref_clk);
        #1;
        check(dummy_cycle, s[0]);
      end
      @(posedge ref_clk);
      #1;
      check({vector_load, stack_push, global_irq_enable, core_run, vector_addr},
            {s[0], s[0], 2'h1, 13'h0004});
      @(posedge ref_clk);
      clear_flags;
    end
    apb(1'h1, 16'h002c, 32'h04, 1'h0);
    flag_set <= 4'h4;
    watchdog_clear_instr <= 1'h1;
    @(posedge ref_clk);
    watchdog_clear_instr <= 1'h0;
    @(posedge ref_clk);
    do_sleep(13'h0, 1'h1);
    clear_flags;
    apb(1'h1, 16'h801c, 32'h00, 1'h0);
    do_sleep(13'h1fff, 1'h0);
    flag_set <= 4'h4;
    wait_for(exec_prefetched, 1'h1, 40);
    check(n >= OST, 1);
    check(verify_read_allow, 0);
    @(posedge ref_clk);
    clear_flags;
    // Postscaler on at ratio two, so a wake needs two base periods
    apb(1'h1, 16'h0204, 32'h09, 1'h0);
    apb(1'h1, 16'h002c, 32'h00, 1'h0);
    apb(1'h1, 16'h801c, 32'h07, 1'h0);
    do_sleep(13'h0, 1'h0);
    wait_for(expiry_flag, 1'h0, 200);
    check(n > 40, 1);
    repeat (2) @(posedge ref_clk);
    #1;
    check({core_run, device_reset, power_down_flag}, 3'h4);
    wait_for(device_reset, 1'h1, 200);
    check({reset_pin_oe, expiry_flag}, 2'h0);
    @(posedge ref_clk);
    apb(1'h0, 16'h0204, 32'hff, 1'h0);
    apb(1'h1, 16'h801c, 32'hf3, 1'h0);
    apb(1'h1, 16'h0204, 32'h00, 1'h0);
    do_sleep(13'h5, 1'h0);
    pin_low <= 1'h1;
    wait_for(device_reset, 1'h1, 4);
    check({core_run, reset_pin_oe}, 2'h2);
    @(posedge ref_clk);
    pin_low <= 1'h0;
    repeat (2) @(posedge ref_clk);
    apb(1'h0, 16'h0204, 32'hff, 1'h0);
    final_report;
  end
endmodule
